// File: core/ppg_pulse_gen.sv
`default_nettype none
// Functional notes
// [RL1] Two byte counters form one 16-bit counter.
// [RL2] Count source: divided clock or external input.
// [RL3] Width match toggles flop, counting continues.
// [RL4] Period match toggles, clears count, raises interrupt.
// [RL5] Initial-level bit loads the toggle flop.
// [RL6] Reset clears the toggle flop.
// [RL7] Output pin is the inverted flop.
// [RL8] Software writes low byte, then high.
// [RL9] Compare registers unbuffered; avoid changes while running.
// [RL10] Stopping holds the output level.
// [RL11] Software stops first, then writes level.
// [RL12] Software sets port latch before use.
// [RL13] Upper control bit 3 runs the counter.
// [RL14] Upper control bit 7 is initial level.
// [RL15] Example control values select source and mode.
// [RL16] Counting begins when run bit written one.
// [RL17] External source counts falling input edges.
// [RL18] Full 16-bit compare on every count.
module ppg_pulse_gen #(
  parameter int CW = 16
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       external_count_input,
  output logic            pulse_output_pin,
  output logic            period_match_irq
);
  logic [7:0]    lower_timer_control_reg;
  logic [7:0]    lower_timer_control_next;
  logic [7:0]    upper_timer_control_reg;
  logic [7:0]    upper_timer_control_next;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] period_next;
  logic [CW-1:0] width_reg;
  logic [CW-1:0] width_next;
  logic [7:0]    irq_status_reg;
  logic [7:0]    irq_status_next;
  logic [7:0]    irq_mask_reg;
  logic [7:0]    irq_mask_next;
  logic [7:0]    rdata_reg;
  logic [7:0]    rdata_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          pulse_toggle_flop_reg;
  logic          pulse_toggle_flop_next;
  logic          ext_meta_reg;
  logic          ext_sync_reg;
  logic          ext_prev_reg;
  logic          run_bit;
  logic          initial_level_bit;
  logic [2:0]    src_sel;
  logic          pres_tick;
  logic          ext_fall;
  logic          count_en;
  logic          width_hit;
  logic          period_hit;
  logic          period_event;

  // Write decode used by every register group.
  function automatic logic wr_at(input logic [3:0] a, input logic [3:0] target, input logic w);
    wr_at = w && (a == target);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Control field extraction.
  always_comb begin
    run_bit           = upper_timer_control_reg[ppg_pkg::UC_RUN_POS];       // [RL13] [RL16]
    initial_level_bit = upper_timer_control_reg[ppg_pkg::UC_INIT_POS];      // [RL14]
    src_sel           = lower_timer_control_reg[ppg_pkg::LC_SRC_LSB +: 3];  // [RL15] 33H gives divide-by-8.
  end

  // Internal divided clock; held in reset while stopped so a start is clean.
  ppg_prescaler #(
    .W(ppg_pkg::PRESC_W)
  ) u_presc (
    .mclk (mclk),
    .rst  (rst),
    .clr  (!run_bit),
    .sel  (src_sel),
    .tick (pres_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // External pin passes two flops before the falling-edge detector sees it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_meta_reg <= 1'b1;
      ext_sync_reg <= 1'b1;
      ext_prev_reg <= 1'b1;
    end else begin
      ext_meta_reg <= external_count_input;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // Count enable selection between prescaler and external falling edges.
  always_comb begin
    ext_fall = ext_prev_reg && !ext_sync_reg;                               // [RL17]
    if (src_sel == ppg_pkg::SRC_EXT) begin
      count_en = run_bit && ext_fall;                                        // [RL2]
    end else begin
      count_en = run_bit && pres_tick;                                       // [RL2]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter and toggle flop. Compares are against the live registers, since
  // they are unbuffered in this mode; a rewrite mid-run can skip a match.
  always_comb begin
    width_hit    = (count_reg == width_reg);                                 // [RL18] [RL9]
    period_hit   = (count_reg == period_reg);                                // [RL18] [RL9]
    period_event = count_en && period_hit;
    count_next   = count_reg;
    pulse_toggle_flop_next = pulse_toggle_flop_reg;
    if (count_en) begin
      if (period_hit) begin
        count_next             = '0;                                         // [RL4]
        pulse_toggle_flop_next = !pulse_toggle_flop_reg;                     // [RL4]
      end else begin
        count_next = count_reg + CW'(1);                                     // [RL1]
        if (width_hit) begin
          pulse_toggle_flop_next = !pulse_toggle_flop_reg;                   // [RL3]
        end
      end
    end else if (wr_at(addr, ppg_pkg::ADDR_UPPER_CTRL, wr) && !run_bit) begin
      // Level is loaded only while stopped, so stopping alone keeps the pin.
      pulse_toggle_flop_next = wdata[ppg_pkg::UC_INIT_POS];                  // [RL5] [RL10] [RL11]
    end
    if (!run_bit && wr_at(addr, ppg_pkg::ADDR_UPPER_CTRL, wr) && wdata[ppg_pkg::UC_RUN_POS]) begin
      count_next = '0;                                                       // [RL16]
    end
  end

  // Counter and flop registers.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_reg             <= '0;
      pulse_toggle_flop_reg <= 1'b0;                                         // [RL6]
    end else begin
      count_reg             <= count_next;
      pulse_toggle_flop_reg <= pulse_toggle_flop_next;
    end
  end

  // The pin always shows the inverse of the flop.
  assign pulse_output_pin = !pulse_toggle_flop_reg;                          // [RL7] [RL12]

  //////////////////////////////////////////////////////////////////////////////
  // Register writes; byte halves land directly, software keeps low-then-high.
  always_comb begin
    lower_timer_control_next = lower_timer_control_reg;
    upper_timer_control_next = upper_timer_control_reg;
    period_next              = period_reg;
    width_next               = width_reg;
    irq_mask_next            = irq_mask_reg;
    if (wr_at(addr, ppg_pkg::ADDR_LOWER_CTRL, wr)) begin
      lower_timer_control_next = wdata;                                      // [RL15]
    end
    if (wr_at(addr, ppg_pkg::ADDR_UPPER_CTRL, wr)) begin
      upper_timer_control_next = wdata;                                      // [RL13] [RL15]
    end
    if (wr_at(addr, ppg_pkg::ADDR_PERIOD_LO, wr)) begin
      period_next[7:0] = wdata;                                              // [RL8]
    end
    if (wr_at(addr, ppg_pkg::ADDR_PERIOD_HI, wr)) begin
      period_next[15:8] = wdata;                                             // [RL8]
    end
    if (wr_at(addr, ppg_pkg::ADDR_WIDTH_LO, wr)) begin
      width_next[7:0] = wdata;                                               // [RL8]
    end
    if (wr_at(addr, ppg_pkg::ADDR_WIDTH_HI, wr)) begin
      width_next[15:8] = wdata;                                              // [RL8]
    end
    if (wr_at(addr, ppg_pkg::ADDR_IRQ_MASK, wr)) begin
      irq_mask_next = wdata;
    end
  end

  // Sticky status: write one clears, but a same-cycle event wins.
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_at(addr, ppg_pkg::ADDR_IRQ_STATUS, wr)) begin
      irq_status_next = irq_status_reg & ~wdata;
    end
    if (period_event) begin
      irq_status_next[ppg_pkg::IRQ_PERIOD_POS] = 1'b1;                       // [RL4]
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    rdata_next = 8'h00;
    if (rd) begin
      case (addr)
        ppg_pkg::ADDR_LOWER_CTRL: rdata_next = lower_timer_control_reg;
        ppg_pkg::ADDR_UPPER_CTRL: rdata_next = upper_timer_control_reg;
        ppg_pkg::ADDR_PERIOD_LO:  rdata_next = period_reg[7:0];
        ppg_pkg::ADDR_PERIOD_HI:  rdata_next = period_reg[15:8];
        ppg_pkg::ADDR_WIDTH_LO:   rdata_next = width_reg[7:0];
        ppg_pkg::ADDR_WIDTH_HI:   rdata_next = width_reg[15:8];
        ppg_pkg::ADDR_IRQ_STATUS: rdata_next = irq_status_reg;
        ppg_pkg::ADDR_IRQ_MASK:   rdata_next = irq_mask_reg;
        ppg_pkg::ADDR_COUNT_LO:   rdata_next = count_reg[7:0];
        ppg_pkg::ADDR_COUNT_HI:   rdata_next = count_reg[15:8];
        default:                  rdata_next = 8'h00;
      endcase
    end
  end

  // Register file storage.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lower_timer_control_reg <= ppg_pkg::CTRL_RST;
      upper_timer_control_reg <= ppg_pkg::CTRL_RST;
      period_reg              <= ppg_pkg::REG16_RST;
      width_reg               <= ppg_pkg::REG16_RST;
      irq_status_reg          <= 8'h00;
      irq_mask_reg            <= ppg_pkg::MASK_RST;
      rdata_reg               <= 8'h00;
    end else begin
      lower_timer_control_reg <= lower_timer_control_next;
      upper_timer_control_reg <= upper_timer_control_next;
      period_reg              <= period_next;
      width_reg               <= width_next;
      irq_status_reg          <= irq_status_next;
      irq_mask_reg            <= irq_mask_next;
      rdata_reg               <= rdata_next;
    end
  end

  assign rdata            = rdata_reg;
  assign period_match_irq = |(irq_status_reg & irq_mask_reg);                // [RL4]
endmodule : ppg_pulse_gen
`default_nettype wire

// File: shared/ppg_pkg.sv
`default_nettype none
package ppg_pkg;
  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_LOWER_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_UPPER_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_PERIOD_LO   = 4'h2;
  localparam logic [3:0] ADDR_PERIOD_HI   = 4'h3;
  localparam logic [3:0] ADDR_WIDTH_LO    = 4'h4;
  localparam logic [3:0] ADDR_WIDTH_HI    = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK    = 4'h7;
  localparam logic [3:0] ADDR_COUNT_LO    = 4'h8;
  localparam logic [3:0] ADDR_COUNT_HI    = 4'h9;
  // Field positions in the upper control register.
  localparam int UC_RUN_POS      = 3;
  localparam int UC_INIT_POS     = 7;
  // Field positions in the lower control register.
  localparam int LC_SRC_LSB      = 4;
  localparam int LC_MODE_LSB     = 0;
  // Values after reset.
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [15:0] REG16_RST  = 16'hFFFF;
  localparam logic [7:0]  MASK_RST   = 8'h00;
  // Source select codes in lower control bits 6:4.
  localparam logic [2:0] SRC_DIV2K  = 3'h0;
  localparam logic [2:0] SRC_DIV128 = 3'h1;
  localparam logic [2:0] SRC_DIV32  = 3'h2;
  localparam logic [2:0] SRC_DIV8   = 3'h3;
  localparam logic [2:0] SRC_EXT    = 3'h4;
  // Prescaler divide ratios for each internal source; the terminal count is one less.
  localparam int DIV_2K  = 2048;
  localparam int DIV_128 = 128;
  localparam int DIV_32  = 32;
  localparam int DIV_8   = 8;
  localparam int PRESC_W = 11;
  // Interrupt status bit.
  localparam int IRQ_PERIOD_POS = 0;
endpackage : ppg_pkg
`default_nettype wire

// File: core/ppg_prescaler.sv
`default_nettype none
// Prescaler, held at zero while clr is high, that emits one-cycle enable pulses at selected rates.
module ppg_prescaler #(
  parameter int W = ppg_pkg::PRESC_W
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] last;

  //////////////////////////////////////////////////////////////////////////////
  // Terminal count for the chosen divider; external select never ticks here.
  always_comb begin
    case (sel)
      ppg_pkg::SRC_DIV2K:  last = W'(ppg_pkg::DIV_2K - 1);
      ppg_pkg::SRC_DIV128: last = W'(ppg_pkg::DIV_128 - 1);
      ppg_pkg::SRC_DIV32:  last = W'(ppg_pkg::DIV_32 - 1);
      ppg_pkg::SRC_DIV8:   last = W'(ppg_pkg::DIV_8 - 1);
      default:             last = '1;
    endcase
    if (clr || cnt_reg >= last) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + W'(1);
    end
    tick = !clr && (cnt_reg == last) && (sel != ppg_pkg::SRC_EXT);
  end

  // Counter register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : ppg_prescaler
`default_nettype wire

// File: verif/ppg_props.sv
`default_nettype none
// Watches the pulse generator ports; helper state tracks the run bit, mask and idle time.
module ppg_props #(
  parameter int CW = 16
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       external_count_input,
  input wire logic       pulse_output_pin,
  input wire logic       period_match_irq
);
  logic       run_q;
  logic [7:0] mask_q;
  logic [1:0] quiet_q;
  wire logic  up_wr = wr && addr == ppg_pkg::ADDR_UPPER_CTRL;
  wire logic  msk_wr = wr && addr == ppg_pkg::ADDR_IRQ_MASK;
  wire logic  sts_wr = wr && addr == ppg_pkg::ADDR_IRQ_STATUS;
  //////////////////////////////////////////////////////////////////////////////
  // The idle count waits three cycles after a stop so that a last tick cannot look like drift.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      mask_q  <= ppg_pkg::MASK_RST;
      quiet_q <= 2'h0;
    end else begin
      if (up_wr) run_q <= wdata[ppg_pkg::UC_RUN_POS];
      if (msk_wr) mask_q <= wdata;
      if (up_wr || run_q) quiet_q <= 2'h0;
      else if (quiet_q != 2'h3) quiet_q <= quiet_q + 2'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // All checks share the single clock and reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_stopped_wr; up_wr && !run_q; endsequence
  sequence s_start; s_stopped_wr ##0 wdata[ppg_pkg::UC_RUN_POS]; endsequence
  property p_rst_vals; $fell(rst) |-> pulse_output_pin && !period_match_irq && rdata == 8'h00; endproperty
  property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  property p_load_lvl; s_stopped_wr |=> pulse_output_pin == !$past(wdata[ppg_pkg::UC_INIT_POS]); endproperty
  property p_start; s_start ##1 !up_wr |=> $stable(pulse_output_pin); endproperty
  property p_hold; quiet_q == 2'h3 |-> $stable(pulse_output_pin); endproperty
  property p_irq_mask; period_match_irq |-> mask_q != 8'h00; endproperty
  property p_irq_fall; $fell(period_match_irq) |-> $past(sts_wr || msk_wr); endproperty
  property p_irq_rise; $rose(period_match_irq) && !$past(msk_wr) |-> $changed(pulse_output_pin) && $past(run_q);
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("outputs wrong after reset");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside the answer cycle");
  a_load_lvl: assert property (p_load_lvl) else $error("stopped write did not load the level");
  a_start: assert property (p_start) else $error("output moved right after start");
  a_hold: assert property (p_hold) else $error("output moved while stopped");
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt high while fully masked");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a clear");
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without a period toggle");
endmodule // ppg_props
bind ppg_pulse_gen ppg_props #(.CW(CW)) i_ppg_props (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .external_count_input(external_count_input), .pulse_output_pin(pulse_output_pin),
  .period_match_irq(period_match_irq));
`default_nettype wire

// File: verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic            mclk = 1'b0;
  logic            rst = 1'b1;
  logic [3:0]      addr = 4'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic            rd_d = 1'b0;
  logic            ext_in = 1'b1;
  wire logic [7:0] rdata;
  wire logic       pin;
  wire logic       irq;
  logic [7:0]      exp_q[$];
  int              err_total = 0;
  int              check_count = 0;
  int              n;
  int              div;
  logic [15:0]     wid;
  logic [15:0]     per;
  //////////////////////////////////////////////////////////////////////////////
  ppg_pulse_gen #(.CW(16)) i_ppg_pulse_gen (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .external_count_input(ext_in), .pulse_output_pin(pin), .period_match_irq(irq));
  // Clock of 100 ns.
  always #50 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  // Shared compare, bus cycle and bounded pin wait.
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  // Low byte goes first, then high; between the two writes the compare sees new low with old high.
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    bus(1'b1, a, v[7:0]);
    bus(1'b1, a + 4'h1, v[15:8]);
  endtask
  task automatic wait_pin(input logic lvl, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge mclk);
      #1;
      cyc++;
    end while (pin !== lvl && cyc < lim);
    if (pin !== lvl) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, lvl, pin);
      finish_test();
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d checks=%0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Read data stands only in the cycle after the strobe, so it is compared there.
  always @(posedge mclk) begin
    if (rd_d) chk({8'h00, exp_q.pop_front()}, {8'h00, rdata});
    rd_d <= rd;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Reset values, level loading, each clock source, interrupt, stop hold, external count.
  initial begin
    n = $urandom(85413);
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(16'h0001, {15'h0, pin});
    rd_reg(ppg_pkg::ADDR_PERIOD_HI, ppg_pkg::REG16_RST[15:8]);
    rd_reg(ppg_pkg::ADDR_UPPER_CTRL, ppg_pkg::CTRL_RST);
    bus(1'b1, 4'hA, 8'h5A);
    rd_reg(4'hA, 8'h00);
    bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'hD7);
    #1 chk(16'h0000, {15'h0, pin});
    for (int i = 0; i < 4; i++) begin
      div = (i == 0) ? ppg_pkg::DIV_8 : (i == 1) ? ppg_pkg::DIV_32 : (i == 2) ? ppg_pkg::DIV_128 : ppg_pkg::DIV_2K;
      wid = {(i == 0) ? 8'h01 : 8'h00, 8'($urandom_range(0, 4))};
      per = wid + 16'($urandom_range(2, 6));
      bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'h57);
      wr16(ppg_pkg::ADDR_WIDTH_LO, wid);
      wr16(ppg_pkg::ADDR_PERIOD_LO, per);
      bus(1'b1, ppg_pkg::ADDR_LOWER_CTRL, {1'b0, 3'(3 - i), 4'h3});
      bus(1'b1, ppg_pkg::ADDR_IRQ_MASK, (i == 0) ? 8'h01 : 8'h00);
      bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'h5F);
      wait_pin(1'b0, (wid + 2) * div, n);
      wait_pin(1'b1, (per + 2) * div, n);
      chk(16'((per - wid) * div), 16'(n));
      wait_pin(1'b0, (per + 2) * div, n);
      chk(16'((wid + 1) * div), 16'(n));
      chk({15'h0, i == 0}, {15'h0, irq});
      rd_reg(ppg_pkg::ADDR_IRQ_STATUS, 8'h01);
      if (i == 0) begin
        bus(1'b1, ppg_pkg::ADDR_IRQ_STATUS, 8'h01);
        bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'h57);
        #1 chk(16'h0000, {15'h0, irq});
        repeat (40) @(posedge mclk);
        #1 chk(16'h0000, {15'h0, pin});
        bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'h57);
        #1 chk(16'h0001, {15'h0, pin});
      end
    end
    bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'h57);
    wr16(ppg_pkg::ADDR_WIDTH_LO, 16'h0002);
    wr16(ppg_pkg::ADDR_PERIOD_LO, 16'h0005);
    rd_reg(ppg_pkg::ADDR_PERIOD_LO, 8'h05);
    bus(1'b1, ppg_pkg::ADDR_LOWER_CTRL, {1'b0, ppg_pkg::SRC_EXT, 4'h3});
    bus(1'b1, ppg_pkg::ADDR_UPPER_CTRL, 8'h5F);
    rd_reg(ppg_pkg::ADDR_COUNT_LO, 8'h00);
    // Slow edges on the count pin leave room for its synchroniser.
    repeat (3) begin
      @(posedge mclk);
      ext_in <= 1'b0;
      repeat (4) @(posedge mclk);
      ext_in <= 1'b1;
      repeat (4) @(posedge mclk);
    end
    rd_reg(ppg_pkg::ADDR_COUNT_LO, 8'h03);
    rd_reg(ppg_pkg::ADDR_COUNT_HI, 8'h00);
    #1 chk(16'h0000, {15'h0, pin});
    repeat (3) @(posedge mclk);
    finish_test();
  end
endmodule // testbench
`default_nettype wire
